// ===== pkg/wdc_pkg.sv
package wdc_pkg;
    // APB byte offsets
    localparam logic [7:0] WDC_CFG_OFFSET = 8'h00;
    localparam logic [7:0] WDC_CTRL_OFFSET = 8'h04;
    localparam logic [7:0] WDC_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] WDC_IRQ_STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] WDC_IRQ_MASK_OFFSET = 8'h10;
    localparam logic [7:0] WDC_COUNT_OFFSET = 8'h14;
    // Configuration word fields
    localparam int WDC_EN1_BIT = 7;
    localparam int WDC_WINDOW_OFF_BIT = 6;
    localparam int WDC_EN0_BIT = 5;
    localparam int WDC_PSA_BIT = 4;
    localparam int WDC_PS_LSB = 0;
    localparam logic [7:0] WDC_CFG_RESET = 8'hFF;
    // Control register fields
    localparam int WDC_SWEN_BIT = 0;
    localparam int WDC_CLEAR_BIT = 1;
    // Interrupt status fields
    localparam int WDC_EV_TIMEOUT = 0;
    localparam int WDC_EV_EARLY = 1;
    localparam int WDC_EV_CLEAR = 2;
    // Hardware enable codes
    localparam logic [1:0] WDC_HW_OFF = 2'h0;
    localparam logic [1:0] WDC_HW_RUN_ONLY = 2'h1;
    localparam logic [1:0] WDC_HW_SOFT = 2'h2;
    localparam logic [1:0] WDC_HW_ON = 2'h3;
    // Prescaler ratios
    localparam logic [7:0] WDC_PRE_SMALL = 8'h20;
    localparam logic [7:0] WDC_PRE_LARGE = 8'h80;
    // Reset pulse length on timeout
    localparam logic [3:0] WDC_RESET_CYCLES = 4'h4;
endpackage

// ===== pkg/wdc_tick_if.sv
`timescale 1ns/1ns
interface wdc_tick_if;
    logic run;
    logic sel128;
    logic restart;
    logic tick;
    modport ctrl (output run, output sel128, output restart, input tick);
    modport pre (input run, input sel128, input restart, output tick);
endinterface

// ===== hdl/wdc_prescaler.sv
`timescale 1ns/1ns
module wdc_prescaler
    import wdc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Tick link
    wdc_tick_if.pre tk
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic tick_next;
    logic tick_reg;
    logic [7:0] ratio;

    always_comb begin
        ratio = tk.sel128 ? WDC_PRE_LARGE : WDC_PRE_SMALL;
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (tk.restart || !tk.run) begin
            cnt_next = 8'h00;
        end else if (cnt_reg == ratio - 8'h01) begin
            cnt_next = 8'h00;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tk.tick = tick_reg;
endmodule

// ===== hdl/wdc_watchdog.sv
`timescale 1ns/1ns
// How it works
// - Enable code 01 counts only while the device runs, halts in sleep and ignores the software enable.
// - Enable code 00 keeps the watchdog off whatever software writes to its enable bit.
// - Window-disable 1 gives plain operation; 0 makes a clear in the first three quarters reset the device.
// - Prescale select 1 divides the clock by 128, 0 divides it by 32.
// - The four-bit postscale code n divides prescaler ticks by two to the power n.
module wdc_watchdog
    import wdc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device status
    input wire logic sleeping,
    input wire logic clearInstr,
    // Outputs
    output logic deviceReset,
    output logic irq
);
    typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_FIRE} wdc_state_t;

    wdc_tick_if tk();

    wdc_state_t state_reg, state_next;
    logic [7:0] cfg_reg, cfg_next;
    logic swEn_reg, swEn_next;
    logic [15:0] post_reg, post_next;
    logic [2:0] ist_reg, ist_next;
    logic [2:0] imask_reg, imask_next;
    logic [3:0] rst_reg, rst_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wrAcc, rdAcc, mapped;
    logic [1:0] hwEn;
    logic active;
    logic [15:0] limit;
    logic clearNow;
    logic early;
    logic [2:0] ev;

    wdc_prescaler u_pre (
        .clk(clk),
        .reset(reset),
        .tk(tk.pre)
    );

    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == WDC_CFG_OFFSET) || (paddr == WDC_CTRL_OFFSET) ||
                    (paddr == WDC_STATUS_OFFSET) || (paddr == WDC_IRQ_STATUS_OFFSET) ||
                    (paddr == WDC_IRQ_MASK_OFFSET) || (paddr == WDC_COUNT_OFFSET);
    assign pslverr = psel && penable && !mapped;

    assign hwEn = {cfg_reg[WDC_EN1_BIT], cfg_reg[WDC_EN0_BIT]};
    always_comb begin
        case (hwEn)
            WDC_HW_OFF: active = 1'b0;
            WDC_HW_RUN_ONLY: active = !sleeping;
            WDC_HW_SOFT: active = swEn_reg;
            WDC_HW_ON: active = 1'b1;
            default: active = 1'b0;
        endcase
    end

    assign limit = 16'h0001 << cfg_reg[WDC_PS_LSB +: 4];
    assign tk.run = active && (state_reg == ST_COUNT);
    assign tk.sel128 = cfg_reg[WDC_PSA_BIT];
    assign clearNow = clearInstr || (wrAcc && paddr == WDC_CTRL_OFFSET && pwdata[WDC_CLEAR_BIT]);
    assign tk.restart = clearNow;
    // Early when fewer than three quarters of the period have passed
    assign early = !cfg_reg[WDC_WINDOW_OFF_BIT] && ({post_reg, 2'b00} < ({2'b00, limit} * 18'h3));

    always_comb begin
        state_next = state_reg;
        post_next = post_reg;
        rst_next = rst_reg;
        ev = 3'h0;
        case (state_reg)
            ST_IDLE: begin
                post_next = 16'h0000;
                if (active) begin
                    state_next = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!active) begin
                    // Sleep halts without losing the count
                    if (hwEn != WDC_HW_RUN_ONLY) begin
                        state_next = ST_IDLE;
                    end
                end else if (clearNow) begin
                    ev[WDC_EV_CLEAR] = 1'b1;
                    post_next = 16'h0000;
                    if (early) begin
                        ev[WDC_EV_EARLY] = 1'b1;
                        state_next = ST_FIRE;
                        rst_next = WDC_RESET_CYCLES;
                    end
                end else if (tk.tick) begin
                    if (post_reg == limit - 16'h0001) begin
                        ev[WDC_EV_TIMEOUT] = 1'b1;
                        post_next = 16'h0000;
                        state_next = ST_FIRE;
                        rst_next = WDC_RESET_CYCLES;
                    end else begin
                        post_next = post_reg + 16'h0001;
                    end
                end
            end
            ST_FIRE: begin
                rst_next = rst_reg - 4'h1;
                if (rst_reg == 4'h1) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_comb begin
        cfg_next = cfg_reg;
        swEn_next = swEn_reg;
        imask_next = imask_reg;
        // Set wins over a write-one clear
        ist_next = ist_reg | ev;
        if (wrAcc) begin
            case (paddr)
                WDC_CFG_OFFSET: cfg_next = pwdata[7:0];
                WDC_CTRL_OFFSET: swEn_next = pwdata[WDC_SWEN_BIT];
                WDC_IRQ_STATUS_OFFSET: ist_next = (ist_reg & ~pwdata[2:0]) | ev;
                WDC_IRQ_MASK_OFFSET: imask_next = pwdata[2:0];
                default: cfg_next = cfg_reg;
            endcase
        end
        rdata_next = rdata_reg;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                WDC_CFG_OFFSET: rdata_next = {24'h000000, cfg_reg};
                WDC_CTRL_OFFSET: rdata_next = {31'h0, swEn_reg};
                WDC_STATUS_OFFSET: rdata_next = {29'h0, deviceReset, tk.run, active};
                WDC_IRQ_STATUS_OFFSET: rdata_next = {29'h0, ist_reg};
                WDC_IRQ_MASK_OFFSET: rdata_next = {29'h0, imask_reg};
                WDC_COUNT_OFFSET: rdata_next = {16'h0000, post_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            cfg_reg <= WDC_CFG_RESET;
            swEn_reg <= 1'b0;
            post_reg <= 16'h0000;
            ist_reg <= 3'h0;
            imask_reg <= 3'h0;
            rst_reg <= 4'h0;
            rdata_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            swEn_reg <= swEn_next;
            post_reg <= post_next;
            ist_reg <= ist_next;
            imask_reg <= imask_next;
            rst_reg <= rst_next;
            rdata_reg <= rdata_next;
        end
    end

    assign prdata = rdAcc ? rdata_reg : 32'h00000000;
    assign deviceReset = (state_reg == ST_FIRE);
    assign irq = |(ist_reg & imask_reg);
endmodule

// ===== testbench/wdc_watchdog_sva.sv
`timescale 1ns/1ns
module wdc_watchdog_sva
    import wdc_pkg::*;
(
    // Clock, reset and bus
    input logic clk,
    input logic reset,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // Device side
    input logic sleeping,
    input logic clearInstr,
    input logic deviceReset,
    input logic irq
);
    logic [7:0] cfgReg;
    logic swEnReg;
    logic wr;
    logic idle;
    logic [1:0] hw;
    assign wr = psel && penable && pwrite;
    assign hw = {cfgReg[WDC_EN1_BIT], cfgReg[WDC_EN0_BIT]};
    // Sleep in run-only mode freezes the count, so it cannot trip either
    assign idle = hw == WDC_HW_OFF || (hw == WDC_HW_SOFT && !swEnReg) || (hw == WDC_HW_RUN_ONLY && sleeping);
    always_ff @(posedge clk) begin
        if (reset) begin
            cfgReg <= WDC_CFG_RESET;
            swEnReg <= 1'b0;
        end else begin
            if (wr && paddr == WDC_CFG_OFFSET) cfgReg <= pwdata[7:0];
            if (wr && paddr == WDC_CTRL_OFFSET) swEnReg <= pwdata[WDC_SWEN_BIT];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence pulse_s;
        deviceReset [*4] ##1 !deviceReset;
    endsequence
    sequence quiet_s;
        !deviceReset [*8];
    endsequence
    a_pulse_len: assert property ($rose(deviceReset) |-> pulse_s) else $error("pulse length");
    a_idle_quiet: assert property (idle [*8] |=> !deviceReset) else $error("trip when off");
    a_no_early_trip: assert property ($fell(deviceReset) && cfgReg == 8'hE0 |-> quiet_s ##1 quiet_s)
        else $error("trip too early");
    a_unmapped_err: assert property (psel && penable && paddr > WDC_COUNT_OFFSET |-> pslverr) else $error("no err");
    a_read_quiet: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0) else $error("prdata");
    a_ready_high: assert property (psel && penable |-> pready) else $error("no ready");
endmodule
bind wdc_watchdog wdc_watchdog_sva chk_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleeping(sleeping), .clearInstr(clearInstr), .deviceReset(deviceReset), .irq(irq));

// ===== testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import wdc_pkg::*;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic sleeping = 1'b0, clearInstr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, deviceReset, irq;
    int n_mismatch = 0, checked = 0, n;
    always #4 clk = ~clk;
    wdc_watchdog wdc_watchdog_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleeping(sleeping), .clearInstr(clearInstr), .deviceReset(deviceReset), .irq(irq));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task results;
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog process ends a wait for ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Samples on the falling edge so registered outputs have settled
    task waitFor(input logic v, input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (deviceReset !== v && n < lim);
    endtask
    task setup(input logic [7:0] c, input logic [31:0] ctl);
        waitFor(1'b0, 50);
        check(32'(deviceReset), 32'h0);
        apb(1'b1, WDC_CFG_OFFSET, {24'h0, c});
        apb(1'b1, WDC_CTRL_OFFSET, ctl);
    endtask
    task pulseClr;
        @(posedge clk);
        clearInstr <= 1'b1;
        @(posedge clk);
        clearInstr <= 1'b0;
    endtask
    task test_regs;
        apb(1'b0, WDC_CFG_OFFSET, 32'h0);
        check(rd, 32'h000000FF);
        apb(1'b0, 8'h18, 32'h0);
        check({rd[30:0], err}, 32'h1);
    endtask
    task test_period;
        logic [7:0] cfgs [3];
        int base [3];
        cfgs = '{8'hE0, 8'hF0, 8'hE1};
        base = '{32, 128, 64};
        for (int i = 0; i < 3; i++) begin
            setup(cfgs[i], 32'h2);
            waitFor(1'b1, 600);
            check(32'(n >= base[i] && n <= base[i] + 8), 32'h1);
            if (i == 0) begin
                // Clear seen and timeout both latched, then wiped by write-one
                apb(1'b0, WDC_IRQ_STATUS_OFFSET, 32'h0);
                check(rd, 32'h5);
                apb(1'b1, WDC_IRQ_STATUS_OFFSET, 32'h7);
            end
        end
    endtask
    task test_enable;
        setup(8'h40, 32'h3);
        waitFor(1'b1, 400);
        check(32'(deviceReset), 32'h0);
        apb(1'b0, WDC_STATUS_OFFSET, 32'h0);
        check(rd, 32'h0);
        setup(8'hC0, 32'h2);
        waitFor(1'b1, 400);
        check(32'(deviceReset), 32'h0);
        apb(1'b1, WDC_CTRL_OFFSET, 32'h1);
        waitFor(1'b1, 200);
        check(32'(deviceReset), 32'h1);
        setup(8'h60, 32'h2);
        sleeping <= 1'b1;
        waitFor(1'b1, 400);
        check(32'(deviceReset), 32'h0);
        apb(1'b1, WDC_CTRL_OFFSET, 32'h0);
        sleeping <= 1'b0;
        waitFor(1'b1, 200);
        check(32'(deviceReset), 32'h1);
    endtask
    task test_window;
        setup(8'hA0, 32'h0);
        apb(1'b1, WDC_IRQ_MASK_OFFSET, 32'h2);
        pulseClr();
        waitFor(1'b1, 8);
        check({irq, deviceReset}, 32'h3);
        apb(1'b1, WDC_IRQ_STATUS_OFFSET, 32'h2);
        @(negedge clk);
        check(32'(irq), 32'h0);
        setup(8'hE0, 32'h2);
        pulseClr();
        waitFor(1'b1, 8);
        check(32'(deviceReset), 32'h0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        test_regs();
        test_period();
        test_enable();
        test_window();
        results();
    end
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule
